// ==== bench/tad_vehicle_model.sv ====
`default_nettype none
// Switches, key receiver and transponder as seen from the controller
module tad_vehicle_model (
   input  wire logic                      i_clk,
   output logic [tad_pkg::N_SW-1:0]       o_sw,
   output logic [tad_pkg::N_CMD-1:0]      o_cmd,
   output logic [tad_pkg::FBK_W-1:0]      o_fbk
);
   timeunit 1ns;
   timeprecision 1ps;
   // Everything closed, locked and quiet at power-up
   initial begin
      o_sw = '0;
      o_cmd = '0;
      o_fbk = 8'h00;
   end
   // Held 8 clocks, then 8 quiet ones so the synchroniser sees each event
   task automatic pulse(input int b);
      @(posedge i_clk) o_cmd[b] <= 1'h1;
      repeat (8) @(posedge i_clk);
      o_cmd[b] <= 1'h0;
      repeat (8) @(posedge i_clk);
   endtask
   // Levels change only just after an edge
   task automatic set_sw(input int b, input logic v);
      @(posedge i_clk) o_sw[b] <= v;
   endtask
   // Feedback byte also changes just after an edge
   task automatic set_fbk(input logic [tad_pkg::FBK_W-1:0] v);
      @(posedge i_clk) o_fbk <= v;
   endtask
endmodule
`default_nettype wire

// ==== bench/theft_alarm_disarm_fsm_tb.sv ====
`default_nettype none
module theft_alarm_disarm_fsm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  sw;
   logic [10:0] cmd;
   logic [7:0]  fbk;
   logic [3:0]  rly;
   logic [31:0] q;
   logic        err;
   int          error_cnt;
   int          comparisons;
   // Variant, start state, 1 for command else switch, bit, end state
   logic [35:0] tbl [13] = '{36'h1_004_1_5_001, 36'h2_004_1_7_001,
      36'h0_004_0_5_001, 36'h4_004_0_5_004, 36'h0_008_0_5_001,
      36'h0_002_0_3_001, 36'h0_002_0_4_001, 36'h0_080_0_2_001,
      36'h0_100_0_1_001, 36'h0_020_1_2_001, 36'h0_040_0_4_001,
      36'h0_010_1_2_001, 36'h0_004_1_0_004};
   tad_disarm_top #(.TICK_CLKS(2)) i_tad_disarm_top (.i_clk(clk),
      .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_sw(sw), .i_cmd(cmd), .i_xpdr_feedback(fbk),
      .o_horn_relay(rly[0]), .o_hazard_relay(rly[1]),
      .o_unlock_relay(rly[2]), .o_start_inhibit_relay(rly[3]));
   tad_vehicle_model i_tad_vehicle_model (.i_clk(clk), .o_sw(sw),
      .o_cmd(cmd), .o_fbk(fbk));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One APB transfer; read data and error land in q and err
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      // Idle edge first, so back-to-back calls never drive psel twice
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Status word: relays are {inhibit, unlock, hazard, horn}
   function automatic logic [31:0] st(logic [8:0] s, logic [3:0] r);
      return {12'h000, r, 7'h00, s};
   endfunction
   task automatic rd_st(input logic [8:0] s, input logic [3:0] r,
                        input logic [31:0] m);
      apb(1'h0, tad_pkg::ADDR_STATUS, 32'h0);
      chk("status", st(s, r) & m, q & m);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
      error_cnt = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rd_st(9'h001, 4'h0, 32'hffffffff);
      apb(1'h0, tad_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h0, q);
      apb(1'h0, 8'h0c, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      // Sounding, then door open plus transmitter unlock
      apb(1'h1, tad_pkg::ADDR_CMD, 32'h010);
      repeat (4) @(posedge clk);
      rd_st(9'h010, 4'hb, 32'hffffffff);
      i_tad_vehicle_model.set_sw(0, 1'h1);
      i_tad_vehicle_model.pulse(0);
      rd_st(9'h001, 4'h4, 32'hffffffff);
      for (int i = 0; i < 4; i++) begin
         repeat (1000) @(posedge clk);
         rd_st(9'h001, i[0] ? 4'h0 : 4'h2, 32'hffffffff);
      end
      // Idle with door open: unlock flashes only
      i_tad_vehicle_model.pulse(0);
      rd_st(9'h001, 4'h2, 32'hffffffff);
      i_tad_vehicle_model.set_sw(0, 1'h0);
      repeat (2100) @(posedge clk);
      // Charge signal held: 3000 ticks of 2 clocks
      apb(1'h1, tad_pkg::ADDR_CMD, 32'h010);
      i_tad_vehicle_model.set_sw(6, 1'h1);
      repeat (5800) @(posedge clk);
      rd_st(9'h010, 4'hb, 32'hffffffff);
      repeat (400) @(posedge clk);
      rd_st(9'h001, 4'h0, 32'hffffffff);
      i_tad_vehicle_model.set_sw(6, 1'h0);
      // Variant only changed while no event is in flight
      foreach (tbl[k]) begin
         apb(1'h1, tad_pkg::ADDR_CTRL, {29'h0, tbl[k][34:32]});
         apb(1'h1, tad_pkg::ADDR_CMD, {23'h0, tbl[k][28:20]});
         if (tbl[k][16]) begin
            i_tad_vehicle_model.pulse(int'(tbl[k][15:12]));
         end else begin
            i_tad_vehicle_model.set_sw(int'(tbl[k][15:12]), 1'h1);
            repeat (16) @(posedge clk);
            i_tad_vehicle_model.set_sw(int'(tbl[k][15:12]), 1'h0);
         end
         rd_st(tbl[k][8:0], 4'h0, 32'h1ff);
         if (k == 1) begin
            chk("hazard", 32'h1, {31'h0, rly[1]});
         end
      end
      // Guard-pending wait runs out after 30000 ticks of 2 clocks
      apb(1'h1, tad_pkg::ADDR_CMD, 32'h002);
      repeat (59900) @(posedge clk);
      rd_st(9'h002, 4'h0, 32'h1ff);
      repeat (200) @(posedge clk);
      rd_st(9'h004, 4'h0, 32'h1ff);
      // Smart variant: feedback low digit 2 disarms, high digit ignored
      apb(1'h1, tad_pkg::ADDR_CTRL, 32'h1);
      i_tad_vehicle_model.set_fbk(8'h52);
      repeat (8) @(posedge clk);
      rd_st(9'h001, 4'h0, 32'h1ff);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== rtl/tad_disarm_top.sv ====
`default_nettype none
// Functional notes
// - Sounding disarms after ignition on 30 s or charge signal on 3 s.
// - Non-smart: door open plus unlock, trunk, or failed lock disarms sounding.
// - Smart: door open plus unlock, trunk, authentication or failed lock disarms sounding.
// - Mechanical option: mechanical unlock or failed mechanical lock disarms sounding.
// - Leaving sounding on a disarm event switches off horn, hazard and start inhibit.
// - Unlock disarm: unlock relay 0.5 s, then two hazard flashes.
// - Each flash phase on 0.5 s and off 0.5 s.
// - Idle, key out, door open: events keep state; unlocks still flash twice.
// - Guard-pending disarms on opening, unlocking, key in, authentication, mechanical.
// - Mechanical unlock from pending, guarding or trunk-hold flashes twice.
// - Relock stage one disarms on opening, key in, failed lock, authentication.
// - Stage two: hood or trunk disarm only if remembered closed.
// - Guarding disarms on ignition (not China), authentication, mechanical unlock.
// - Re-guard disarms on drive timers (not China), trunk, failed lock, auth, mechanical.
// - Disarm from re-guard switches start inhibit off.
// - Pre-guard disarms on key, unlocked-closed, door open plus unlock, auth; flashes twice.
// - Trunk-hold disarms on ignition, authentication or mechanical unlock.
// - Guard-pending timer expiry moves to guarding.
// - Entering sounding drives horn once 27 s with hazard alongside.
module tad_disarm_top #(
   parameter int TICK_CLKS = tad_pkg::TICK_CLKS
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [7:0]                i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output logic      [31:0]               o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   input  wire logic [tad_pkg::N_SW-1:0]  i_sw,
   input  wire logic [tad_pkg::N_CMD-1:0] i_cmd,
   input  wire logic [tad_pkg::FBK_W-1:0] i_xpdr_feedback,
   output logic                           o_horn_relay,
   output logic                           o_hazard_relay,
   output logic                           o_unlock_relay,
   output logic                           o_start_inhibit_relay
);
   if (TICK_CLKS < 1 || TICK_CLKS >= (1 << 20)) begin : g_chk
      $error("TICK_CLKS out of range");
   end

   tad_pin_if #(.W(tad_pkg::N_PIN)) pins ();
   assign pins.raw = {i_xpdr_feedback, i_cmd, i_sw};
   tad_sync u_sync (.i_clk(i_clk), .i_rst_n(i_rst_n), .p(pins.sync_side));

   tad_pkg::tad_state_t state_r;
   tad_pkg::tad_state_t state_nxt;
   tad_pkg::tad_ack_t   ack_r;
   logic [tad_pkg::N_SW-1:0]  sw;
   logic [tad_pkg::N_CMD-1:0] cmd_d_r;
   logic [tad_pkg::N_CMD-1:0] ev;
   logic [2:0]  ctrl_r;
   logic [19:0] tick_cnt_r;
   logic        tick_r;
   logic [15:0] ign_cnt_r;
   logic [15:0] chg_cnt_r;
   logic [15:0] wait_cnt_r;
   logic [15:0] horn_cnt_r;
   logic [15:0] ack_cnt_r;
   logic        fbk_hit_r;
   logic        hood_mem_r;
   logic        trunk_mem_r;
   logic        horn_r;
   logic        inhibit_r;
   logic        cmd_wr;
   logic        do_ack;
   logic        do_unlock_ack;
   logic        smart;
   logic        mech;
   logic        china;
   logic        door_ev;
   logic        open_ev;
   logic        unlock_ev;
   logic        lock_fail_ev;
   logic        trunk_ev;
   logic        auth_ev;
   logic        mech_unlock_ev;
   logic        key_in_ev;
   logic        ign_ev;
   logic        drive_done;
   logic        wait_done;

   // Strobe helpers shared by the decode below
   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction

   function automatic logic flash_on(input tad_pkg::tad_ack_t a);
      flash_on = (a == tad_pkg::ACK_ON1) || (a == tad_pkg::ACK_ON2);
   endfunction

   assign sw = pins.clean[tad_pkg::N_SW-1:0];
   assign ev = pins.clean[tad_pkg::N_SW +: tad_pkg::N_CMD] & ~cmd_d_r;
   // Variant bits are assumed static while running
   assign smart = ctrl_r[tad_pkg::CTRL_SMART_KEY];
   assign mech  = ctrl_r[tad_pkg::CTRL_MECH_OPTION];
   assign china = ctrl_r[tad_pkg::CTRL_CHINA];

   // Edge memory for commands and switch events
   logic [tad_pkg::N_SW-1:0] sw_d_r;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cmd_d_r   <= '0;
         sw_d_r    <= '0;
         fbk_hit_r <= 1'b0;
      end else begin
         cmd_d_r   <= pins.clean[tad_pkg::N_SW +: tad_pkg::N_CMD];
         sw_d_r    <= sw;
         fbk_hit_r <= pins.clean[tad_pkg::N_PIN-tad_pkg::FBK_W +: 4]
                      == tad_pkg::FBK_MATCH_LOW;
      end
   end

   // Event decode; feedback high digit is ignored
   logic fbk_now;
   assign fbk_now = pins.clean[tad_pkg::N_PIN-tad_pkg::FBK_W +: 4]
                    == tad_pkg::FBK_MATCH_LOW;
   assign door_ev  = rise(sw[tad_pkg::SW_DOOR_OPEN], sw_d_r[0]);
   assign open_ev  = |(sw[2:0] & ~sw_d_r[2:0]);
   assign key_in_ev = rise(sw[tad_pkg::SW_KEY_IN], sw_d_r[4]);
   assign ign_ev   = rise(sw[tad_pkg::SW_IGNITION], sw_d_r[5]);
   assign unlock_ev = ev[tad_pkg::CMD_REMOTE_UNLOCK]
                    | (smart & ev[tad_pkg::CMD_PASSIVE_UNLOCK]);
   assign lock_fail_ev = sw[tad_pkg::SW_LOCK_FAIL]
      & (ev[tad_pkg::CMD_REMOTE_LOCK] | (smart & ev[tad_pkg::CMD_PASSIVE_LOCK])
         | (mech & ev[tad_pkg::CMD_MECH_LOCK]));
   assign trunk_ev = ev[tad_pkg::CMD_REMOTE_TRUNK];
   assign auth_ev = smart & (ev[tad_pkg::CMD_XPDR_AUTH]
      | ev[tad_pkg::CMD_IMMO_AUTH] | rise(fbk_now, fbk_hit_r));
   assign mech_unlock_ev = mech & ev[tad_pkg::CMD_MECH_UNLOCK];
   assign drive_done = (ign_cnt_r == tad_pkg::IGNITION_TICKS)
                     | (chg_cnt_r == tad_pkg::CHARGE_TICKS);
   assign wait_done  = wait_cnt_r == tad_pkg::GUARD_WAIT_TICKS;

   // Fixed time base for every duration
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tick_cnt_r <= 20'h00000;
         tick_r     <= 1'b0;
      end else begin
         tick_r     <= tick_cnt_r == 20'(TICK_CLKS - 1);
         tick_cnt_r <= (tick_cnt_r == 20'(TICK_CLKS - 1)) ? 20'h00000
                                                         : tick_cnt_r + 20'h1;
      end
   end

   // Level timers restart when the level drops
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ign_cnt_r <= 16'h0000;
         chg_cnt_r <= 16'h0000;
      end else begin
         if (!sw[tad_pkg::SW_IGNITION]) ign_cnt_r <= 16'h0000;
         else if (tick_r && ign_cnt_r != tad_pkg::IGNITION_TICKS)
            ign_cnt_r <= ign_cnt_r + 16'h1;
         if (!sw[tad_pkg::SW_CHARGE]) chg_cnt_r <= 16'h0000;
         else if (tick_r && chg_cnt_r != tad_pkg::CHARGE_TICKS)
            chg_cnt_r <= chg_cnt_r + 16'h1;
      end
   end

   // Disarm decisions; hardware events choose the next state
   always_comb begin
      state_nxt     = state_r;
      do_ack        = 1'b0;
      do_unlock_ack = 1'b0;
      unique case (state_r)
         tad_pkg::ST_SOUNDING: begin
            if (drive_done || (sw[0] && unlock_ev) || trunk_ev
                || lock_fail_ev || auth_ev || mech_unlock_ev) begin
               state_nxt     = tad_pkg::ST_DISARM;
               do_unlock_ack = sw[0] && unlock_ev;
            end
         end
         tad_pkg::ST_DISARM: begin
            do_ack = !sw[tad_pkg::SW_KEY_IN] && sw[0] && unlock_ev;
         end
         tad_pkg::ST_GUARD_PENDING: begin
            if (open_ev || rise(sw[3], sw_d_r[3]) || key_in_ev || auth_ev
                || mech_unlock_ev) begin
               state_nxt = tad_pkg::ST_DISARM;
               do_ack    = mech_unlock_ev;
            end else if (wait_done) begin
               state_nxt = tad_pkg::ST_GUARDING;
            end
         end
         tad_pkg::ST_RELOCK_ONE: begin
            if (open_ev || key_in_ev || lock_fail_ev || auth_ev
                || (ev[tad_pkg::CMD_AUTO_LOCK] && sw[tad_pkg::SW_LOCK_FAIL]))
               state_nxt = tad_pkg::ST_DISARM;
         end
         tad_pkg::ST_RELOCK_TWO: begin
            if (door_ev || key_in_ev || lock_fail_ev || auth_ev
                || (ev[tad_pkg::CMD_AUTO_LOCK] && sw[tad_pkg::SW_LOCK_FAIL])
                || (rise(sw[1], sw_d_r[1]) && hood_mem_r)
                || (rise(sw[2], sw_d_r[2]) && trunk_mem_r))
               state_nxt = tad_pkg::ST_DISARM;
         end
         tad_pkg::ST_GUARDING, tad_pkg::ST_TRUNK_HOLD: begin
            if ((ign_ev && (!china || state_r == tad_pkg::ST_TRUNK_HOLD))
                || auth_ev || mech_unlock_ev) begin
               state_nxt = tad_pkg::ST_DISARM;
               do_ack    = mech_unlock_ev;
            end
         end
         tad_pkg::ST_REGUARD: begin
            if ((!china && drive_done) || trunk_ev || lock_fail_ev || auth_ev
                || ev[tad_pkg::CMD_TRUNK_REOPEN] || mech_unlock_ev) begin
               state_nxt = tad_pkg::ST_DISARM;
               do_ack    = mech_unlock_ev;
            end
         end
         tad_pkg::ST_PRE_GUARD: begin
            if (key_in_ev || (~|sw[2:0] && sw[3]) || (sw[0] && unlock_ev)
                || auth_ev || mech_unlock_ev) begin
               state_nxt = tad_pkg::ST_DISARM;
               do_ack    = 1'b1;
            end
         end
         default: state_nxt = tad_pkg::ST_DISARM;
      endcase
   end

   // State register; a software state write takes precedence
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) state_r <= tad_pkg::ST_DISARM;
      else if (cmd_wr && $onehot(i_pwdata[8:0]))
         state_r <= tad_pkg::tad_state_t'(i_pwdata[8:0]);
      else state_r <= state_nxt;
   end

   // Guard wait timer and stage-two hood/trunk memory
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wait_cnt_r  <= 16'h0000;
         hood_mem_r  <= 1'b0;
         trunk_mem_r <= 1'b0;
      end else begin
         if (state_r != tad_pkg::ST_GUARD_PENDING) wait_cnt_r <= 16'h0000;
         else if (tick_r && !wait_done) wait_cnt_r <= wait_cnt_r + 16'h1;
         if (state_r != tad_pkg::ST_RELOCK_TWO) begin
            hood_mem_r  <= !sw[tad_pkg::SW_HOOD_OPEN];
            trunk_mem_r <= !sw[tad_pkg::SW_TRUNK_OPEN];
         end
      end
   end

   // Horn once per sounding entry; inhibit until disarm
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         horn_r     <= 1'b0;
         horn_cnt_r <= 16'h0000;
         inhibit_r  <= 1'b0;
      end else if (state_r != tad_pkg::ST_SOUNDING) begin
         horn_r     <= 1'b0;
         horn_cnt_r <= 16'h0000;
         if (state_r == tad_pkg::ST_REGUARD && state_nxt != state_r)
            inhibit_r <= 1'b0;
      end else if (state_nxt != tad_pkg::ST_SOUNDING) begin
         horn_r    <= 1'b0;
         inhibit_r <= 1'b0;
      end else begin
         horn_r <= horn_cnt_r != tad_pkg::HORN_TICKS;
         if (horn_cnt_r == 16'h0000) inhibit_r <= 1'b1;
         if (tick_r && horn_cnt_r != tad_pkg::HORN_TICKS)
            horn_cnt_r <= horn_cnt_r + 16'h1;
      end
   end

   // Unlock pulse then two flashes; a new request restarts it
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ack_r     <= tad_pkg::ACK_IDLE;
         ack_cnt_r <= 16'h0000;
      end else if (do_unlock_ack) begin
         ack_r     <= tad_pkg::ACK_UNLOCK;
         ack_cnt_r <= 16'h0000;
      end else if (do_ack) begin
         ack_r     <= tad_pkg::ACK_ON1;
         ack_cnt_r <= 16'h0000;
      end else if (ack_r != tad_pkg::ACK_IDLE && tick_r) begin
         if (ack_cnt_r == tad_pkg::FLASH_TICKS - 16'h1) begin
            ack_cnt_r <= 16'h0000;
            ack_r <= (ack_r == tad_pkg::ACK_OFF2) ? tad_pkg::ACK_IDLE
                     : tad_pkg::tad_ack_t'(ack_r + 3'h1);
         end else begin
            ack_cnt_r <= ack_cnt_r + 16'h1;
         end
      end
   end

   // Relay drivers straight from flops
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_horn_relay          <= 1'b0;
         o_hazard_relay        <= 1'b0;
         o_unlock_relay        <= 1'b0;
         o_start_inhibit_relay <= 1'b0;
      end else begin
         o_horn_relay          <= horn_r;
         o_hazard_relay        <= horn_r | flash_on(ack_r);
         o_unlock_relay        <= ack_r == tad_pkg::ACK_UNLOCK;
         o_start_inhibit_relay <= inhibit_r;
      end
   end

   // APB slave: no wait states, error on unmapped address
   logic mapped;
   assign mapped = i_paddr == tad_pkg::ADDR_CTRL
                || i_paddr == tad_pkg::ADDR_CMD
                || i_paddr == tad_pkg::ADDR_STATUS;
   assign cmd_wr = i_psel && i_penable && o_pready && i_pwrite
                && i_paddr == tad_pkg::ADDR_CMD;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h00000000;
         ctrl_r    <= tad_pkg::CTRL_RESET;
      end else begin
         o_pready  <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !mapped;
         o_prdata  <= 32'h00000000;
         if (i_psel && !i_penable && !i_pwrite) begin
            if (i_paddr == tad_pkg::ADDR_CTRL) o_prdata <= {29'h0, ctrl_r};
            if (i_paddr == tad_pkg::ADDR_STATUS)
               o_prdata <= {12'h000, o_start_inhibit_relay, o_unlock_relay,
                            o_hazard_relay, o_horn_relay, 7'h00, state_r};
         end
         if (i_psel && i_penable && o_pready && i_pwrite
             && i_paddr == tad_pkg::ADDR_CTRL)
            ctrl_r <= i_pwdata[2:0];
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_unlock_end;
      ack_r == tad_pkg::ACK_UNLOCK ##1 ack_r != tad_pkg::ACK_UNLOCK;
   endsequence
   sequence s_leave_sounding;
      state_r == tad_pkg::ST_SOUNDING ##1 state_r == tad_pkg::ST_DISARM;
   endsequence

   a_horn_off_exit: assert property (s_leave_sounding |=> !o_horn_relay
      && !o_start_inhibit_relay) else $error("relay left on after disarm");
   a_drive_disarm: assert property (state_r == tad_pkg::ST_SOUNDING
      && drive_done && !cmd_wr |=> state_r == tad_pkg::ST_DISARM)
      else $error("drive timer did not disarm");
   a_unlock_flash: assert property (s_unlock_end |-> ack_r ==
      tad_pkg::ACK_ON1 || ack_r == tad_pkg::ACK_UNLOCK || do_ack)
      else $error("flash did not follow unlock pulse");
   a_flash_phase: assert property (ack_r != $past(ack_r) && !$past(do_ack)
      && !$past(do_unlock_ack) |-> $past(ack_cnt_r) == tad_pkg::FLASH_TICKS
      - 16'h1 && $past(tick_r)) else $error("flash phase wrong length");
   a_wait_expiry: assert property (state_r == tad_pkg::ST_GUARD_PENDING
      ##1 state_r == tad_pkg::ST_GUARDING |-> $past(wait_done) || $past(cmd_wr))
      else $error("guarding entered early");
   a_horn_bound: assert property (horn_cnt_r <= tad_pkg::HORN_TICKS
      and (horn_cnt_r == tad_pkg::HORN_TICKS |=> !horn_r))
      else $error("horn ran past its time");
   a_reguard_inhibit: assert property (state_r == tad_pkg::ST_REGUARD
      && state_nxt == tad_pkg::ST_DISARM && !cmd_wr |=> !inhibit_r)
      else $error("start inhibit left on");
   a_pre_guard_ack: assert property (state_r == tad_pkg::ST_PRE_GUARD
      && state_nxt == tad_pkg::ST_DISARM && !cmd_wr && !do_unlock_ack
      |=> ack_r == tad_pkg::ACK_ON1) else $error("no flash from pre-guard");
   a_ign_restart: assert property (!sw[tad_pkg::SW_IGNITION] |=>
      ign_cnt_r == 16'h0000) else $error("ignition timer not restarted");
endmodule
`default_nettype wire

// ==== rtl/tad_pin_if.sv ====
`default_nettype none
interface tad_pin_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync_side (input raw, output clean);
   modport user_side (output raw, input clean);
endinterface
`default_nettype wire

// ==== rtl/tad_pkg.sv ====
`default_nettype none
package tad_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CLKS     = TICK_NS / CLK_PERIOD_NS;
   localparam int MS_PER_S      = 1000;
   localparam int TICK_MS       = TICK_NS / 1000000;

   // Durations in their own unit, then in ticks
   localparam int IGNITION_HOLD_S  = 30;
   localparam int CHARGE_HOLD_S    = 3;
   localparam int HORN_S           = 27;
   localparam int UNLOCK_PULSE_MS  = 500;
   localparam int FLASH_PHASE_MS   = 500;
   localparam int GUARD_WAIT_S     = 30;
   localparam logic [15:0] IGNITION_TICKS =
      16'(IGNITION_HOLD_S * MS_PER_S / TICK_MS);
   localparam logic [15:0] CHARGE_TICKS =
      16'(CHARGE_HOLD_S * MS_PER_S / TICK_MS);
   localparam logic [15:0] HORN_TICKS = 16'(HORN_S * MS_PER_S / TICK_MS);
   localparam logic [15:0] UNLOCK_TICKS = 16'(UNLOCK_PULSE_MS / TICK_MS);
   localparam logic [15:0] FLASH_TICKS = 16'(FLASH_PHASE_MS / TICK_MS);
   localparam logic [15:0] GUARD_WAIT_TICKS =
      16'(GUARD_WAIT_S * MS_PER_S / TICK_MS);

   // Register map (byte addresses) and fields
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_SMART_KEY   = 0;
   localparam int CTRL_MECH_OPTION = 1;
   localparam int CTRL_CHINA       = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int STATUS_RELAY_LSB = 16;

   // Switch levels on i_sw
   localparam int SW_DOOR_OPEN     = 0;
   localparam int SW_HOOD_OPEN     = 1;
   localparam int SW_TRUNK_OPEN    = 2;
   localparam int SW_DOOR_UNLOCKED = 3;
   localparam int SW_KEY_IN        = 4;
   localparam int SW_IGNITION      = 5;
   localparam int SW_CHARGE        = 6;
   localparam int SW_LOCK_FAIL     = 7;
   localparam int N_SW             = 8;
   // Command levels on i_cmd, each counted on its rising edge
   localparam int CMD_REMOTE_UNLOCK  = 0;
   localparam int CMD_REMOTE_LOCK    = 1;
   localparam int CMD_REMOTE_TRUNK   = 2;
   localparam int CMD_PASSIVE_UNLOCK = 3;
   localparam int CMD_PASSIVE_LOCK   = 4;
   localparam int CMD_XPDR_AUTH      = 5;
   localparam int CMD_IMMO_AUTH      = 6;
   localparam int CMD_MECH_UNLOCK    = 7;
   localparam int CMD_MECH_LOCK      = 8;
   localparam int CMD_AUTO_LOCK      = 9;
   localparam int CMD_TRUNK_REOPEN   = 10;
   localparam int N_CMD              = 11;
   localparam int FBK_W              = 8;
   localparam logic [3:0] FBK_MATCH_LOW = 4'h2;
   localparam int N_PIN = N_SW + N_CMD + FBK_W;

   typedef enum logic [8:0] {
      ST_DISARM         = 9'h001,
      ST_GUARD_PENDING  = 9'h002,
      ST_GUARDING       = 9'h004,
      ST_TRUNK_HOLD     = 9'h008,
      ST_SOUNDING       = 9'h010,
      ST_REGUARD        = 9'h020,
      ST_PRE_GUARD      = 9'h040,
      ST_RELOCK_ONE     = 9'h080,
      ST_RELOCK_TWO     = 9'h100
   } tad_state_t;

   // Acknowledge sequence steps
   typedef enum logic [2:0] {
      ACK_IDLE = 3'h0, ACK_UNLOCK = 3'h1, ACK_ON1 = 3'h2,
      ACK_OFF1 = 3'h3, ACK_ON2 = 3'h4, ACK_OFF2 = 3'h5
   } tad_ack_t;
endpackage
`default_nettype wire

// ==== rtl/tad_sync.sv ====
`default_nettype none
module tad_sync (
   input  wire logic      i_clk,
   input  wire logic      i_rst_n,
   tad_pin_if.sync_side   p
);
   logic [$bits(p.raw)-1:0] s1_r;
   logic [$bits(p.raw)-1:0] s2_r;
   logic [$bits(p.raw)-1:0] s3_r;
   logic [$bits(p.raw)-1:0] clean_r;

   // Three-stage chain; first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= p.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a bit once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         clean_r <= '0;
      end else begin
         clean_r <= (clean_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
      end
   end

   assign p.clean = clean_r;
endmodule
`default_nettype wire
